// >>> src/caw_pkg.sv
// Constants, types and helpers for the counter array waveform and watchdog block.
// Assumes one system clock at 50 MHz and an AXI4-Lite master with 8-bit byte addresses.
package caw_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CAW_A_CTRL = 8'h00;
  localparam logic [7:0] CAW_A_MODE = 8'h04;
  localparam logic [7:0] CAW_A_PWMCFG = 8'h08;
  localparam logic [7:0] CAW_A_CNTL = 8'h0c;
  localparam logic [7:0] CAW_A_CNTH = 8'h10;
  localparam logic [2:0] CAW_CH_FIRST = 3'h2;  // Channel n sits at 0x20 + 0x10*n
  localparam logic [3:0] CAW_CH_MODE = 4'h0;
  localparam logic [3:0] CAW_CH_LOW = 4'h4;
  localparam logic [3:0] CAW_CH_HIGH = 4'h8;
  // ----------------------------------------------------------------
  // Field positions, reset values, channel count and watchdog channel
  // ----------------------------------------------------------------
  localparam int CAW_CTRL_CF = 7;
  localparam int CAW_CTRL_CR = 6;
  localparam int CAW_CTRL_WDFLAG = 5;
  localparam int CAW_MODE_IDLE_SUSPEND_BIT = 7;
  localparam int CAW_MODE_WATCHDOG_ENABLE_BIT = 6;
  localparam int CAW_MODE_WATCHDOG_LOCK_BIT = 5;
  localparam int CAW_MODE_CPS_LSB = 1;
  localparam int CAW_MODE_ECF = 0;
  localparam int CAW_PWM_RELOAD_SELECT_BIT = 7;
  localparam int CAW_PWM_ECOV = 6;
  localparam int CAW_PWM_INTERMEDIATE_OVERFLOW_FLAG = 5;
  localparam int CAW_PWM_CL_LSB = 0;
  localparam logic [7:0] CAW_MODE_RST = 8'h40;
  localparam int CAW_NCH = 6;
  localparam int CAW_WD_CH = 5;
  // ----------------------------------------------------------------
  // Timing: array clock divisors of the system clock; AXI response codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CAW_DIV_SYS12 = 4'hc;
  localparam logic [3:0] CAW_DIV_SYS4 = 4'h4;
  localparam logic [1:0] CAW_RESP_OKAY = 2'h0;
  localparam logic [1:0] CAW_RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wide; logic ecom; logic capp; logic capn; logic mat; logic tog; logic pwm; logic eccf;
  } caw_chmode_t;
  typedef enum logic [4:0] {
    CAW_EM_OTHER = 5'h01, CAW_EM_FREQ = 5'h02, CAW_EM_PWMS = 5'h04,
    CAW_EM_PWM16 = 5'h08, CAW_EM_WDOG = 5'h10
  } caw_emode_t;
  // Effective mode of one channel; the watchdog overrides the mode register
  function automatic caw_emode_t caw_decode(caw_chmode_t m, logic wd);
    if (wd) return CAW_EM_WDOG;
    // Comparator enable only gates the toggle, so a low-byte write holds the pin
    if (m.pwm && m.tog) return CAW_EM_FREQ;
    if (m.pwm && m.wide) return CAW_EM_PWM16;
    if (m.pwm) return CAW_EM_PWMS;
    return CAW_EM_OTHER;
  endfunction
  // Counter bits that take part in an 8..11-bit cycle
  function automatic logic [15:0] caw_cl_mask(logic [1:0] cl);
    case (cl)
      2'h0: return 16'h00ff;
      2'h1: return 16'h01ff;
      2'h2: return 16'h03ff;
      default: return 16'h07ff;
    endcase
  endfunction
  // Aligned, mapped register address
  function automatic logic caw_addr_ok(logic [7:0] a);
    return (a[1:0] == 2'h0) && ((a <= CAW_A_CNTH) ||
      (!a[7] && (a[6:4] >= CAW_CH_FIRST) && (a[3:2] != 2'h3)));
  endfunction
endpackage

// >>> src/caw_top.sv
// Counter array with six compare channels: frequency output, 8..11-bit and 16-bit PWM,
// channel 5 doubling as watchdog. Registers over AXI4-Lite on the system clock.
// Assumes i_cpu_idle comes from logic on the same clock; the reset output is
// consumed by the system reset controller.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module caw_top
  import caw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_cpu_idle,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [5:0] o_channel_output_pin,
  output logic o_wdt_reset
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] cap_q [CAW_NCH];
  logic [15:0] arl_q [CAW_NCH];
  caw_chmode_t mode_q [CAW_NCH];
  logic [5:0] pin_q, ccf_q;
  logic cf_q, intermediate_overflow_flag_q, cr_q, idle_suspend_bit_q, watchdog_enable_bit_q, watchdog_lock_bit_q, ecf_q, reload_select_bit_q, ecov_q;
  logic [2:0] cps_q;
  logic [1:0] cl_q;
  logic [3:0] div_q;
  logic wdt_reset_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] wr_addr_q, wr_data_q, rdata_q;
  logic wr_strb_q;

  // ----------------------------------------------------------------
  // Array tick and event decode
  // ----------------------------------------------------------------
  logic wdt_on, run_eff, suspend, div_hit, tick_en;
  logic [15:0] cnt_nx, cl_mask;
  logic ovf8, ovf_cl, ovf16, wd_match;
  logic [7:0] wd_reload;
  caw_emode_t emode [CAW_NCH];
  logic [5:0] lo_match, full_match, pwms_match, ccf_set;

  assign wdt_on = watchdog_enable_bit_q | watchdog_lock_bit_q;
  assign run_eff = cr_q | wdt_on;
  assign suspend = idle_suspend_bit_q & i_cpu_idle;
  // Select 0 is sys/12, 1 is sys/4, anything else runs at the system clock
  assign div_hit = (cps_q == 3'h0) ? (div_q == 4'(CAW_DIV_SYS12 - 4'h1)) :
                   (cps_q == 3'h1) ? (div_q == 4'(CAW_DIV_SYS4 - 4'h1)) : 1'b1;
  assign tick_en = i_clk_en & run_eff & ~suspend & div_hit;
  // Pins and flags compare against the value the counter takes at this tick,
  // so duty works out as (2^N - value)/2^N without an extra cycle of slip
  assign cnt_nx = 16'(cnt_q + 16'h1);
  assign cl_mask = caw_cl_mask(cl_q);
  assign ovf8 = (cnt_q[7:0] == 8'hff);
  assign ovf_cl = ((cnt_q & cl_mask) == cl_mask);
  assign ovf16 = (cnt_q == 16'hffff);
  // Watchdog fires when the low byte wraps while the high bytes agree
  assign wd_match = tick_en & wdt_on & ovf8 & (cap_q[CAW_WD_CH][15:8] == cnt_q[15:8]);
  assign wd_reload = 8'(cnt_q[15:8] + cap_q[CAW_WD_CH][7:0]);

  // Per-channel compare results and hardware flag sets
  always_comb begin
    for (int i = 0; i < CAW_NCH; i++) begin
      emode[i] = caw_decode(mode_q[i], (i == CAW_WD_CH) && wdt_on);
      lo_match[i] = (cnt_nx[7:0] == cap_q[i][7:0]);
      full_match[i] = (cnt_nx == cap_q[i]);
      pwms_match[i] = ((cnt_nx & cl_mask) == (cap_q[i] & cl_mask));
      ccf_set[i] = 1'b0;
      if (tick_en && mode_q[i].ecom && mode_q[i].mat && emode[i] != CAW_EM_WDOG) begin
        ccf_set[i] = (emode[i] == CAW_EM_PWMS) ? pwms_match[i] : full_match[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic wr_do, we, w_ctrl, w_mode, w_pwm, w_cntl, w_cnth, w_is_ch;
  logic [2:0] w_ch;
  logic [5:0] w_cm, w_lo, w_hi;

  assign wr_do = i_clk_en & ~awready_q & ~wready_q & ~bvalid_q;
  assign we = wr_do & wr_strb_q & caw_addr_ok(wr_addr_q);
  assign w_ctrl = we & (wr_addr_q == CAW_A_CTRL);
  assign w_mode = we & (wr_addr_q == CAW_A_MODE);
  assign w_pwm = we & (wr_addr_q == CAW_A_PWMCFG);
  assign w_cntl = we & (wr_addr_q == CAW_A_CNTL);
  assign w_cnth = we & (wr_addr_q == CAW_A_CNTH);
  assign w_is_ch = we & ~wr_addr_q[7] & (wr_addr_q[6:4] >= CAW_CH_FIRST);
  assign w_ch = 3'(wr_addr_q[6:4] - CAW_CH_FIRST);

  always_comb begin
    for (int i = 0; i < CAW_NCH; i++) begin
      w_cm[i] = w_is_ch && (w_ch == 3'(i)) && (wr_addr_q[3:0] == CAW_CH_MODE);
      w_lo[i] = w_is_ch && (w_ch == 3'(i)) && (wr_addr_q[3:0] == CAW_CH_LOW);
      w_hi[i] = w_is_ch && (w_ch == 3'(i)) && (wr_addr_q[3:0] == CAW_CH_HIGH);
    end
  end

  // ----------------------------------------------------------------
  // Array clock divider and counter
  // ----------------------------------------------------------------
  // Divider only moves while the counter may run and holds its count when stopped, so a restart resumes the partial period
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      div_q <= 4'h0;
    end else if (i_clk_en && run_eff && !suspend) begin
      div_q <= div_hit ? 4'h0 : 4'(div_q + 4'h1);
    end
  end

  // Counter: software writes win over the tick, but not while the watchdog guards it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (tick_en) begin
        cnt_q <= cnt_nx;
      end
      if (w_cntl && !wdt_on) begin
        cnt_q[7:0] <= wr_data_q;
      end
      if (w_cnth && !wdt_on) begin
        cnt_q[15:8] <= wr_data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cr_q <= 1'b0;
      {idle_suspend_bit_q, watchdog_enable_bit_q, watchdog_lock_bit_q} <= CAW_MODE_RST[7:5];
      cps_q <= CAW_MODE_RST[3:1];
      ecf_q <= CAW_MODE_RST[0];
      reload_select_bit_q <= 1'b0;
      ecov_q <= 1'b0;
      cl_q <= 2'h0;
    end else if (i_clk_en) begin
      if (w_ctrl) begin
        cr_q <= wr_data_q[CAW_CTRL_CR];
      end
      if (w_mode) begin
        // Clock select and idle control are frozen while the watchdog is on
        if (!wdt_on) begin
          idle_suspend_bit_q <= wr_data_q[CAW_MODE_IDLE_SUSPEND_BIT];
          cps_q <= wr_data_q[CAW_MODE_CPS_LSB +: 3];
        end
        watchdog_enable_bit_q <= wr_data_q[CAW_MODE_WATCHDOG_ENABLE_BIT] | watchdog_lock_bit_q;
        watchdog_lock_bit_q <= watchdog_lock_bit_q | wr_data_q[CAW_MODE_WATCHDOG_LOCK_BIT];
        ecf_q <= wr_data_q[CAW_MODE_ECF];
      end
      if (w_pwm) begin
        reload_select_bit_q <= wr_data_q[CAW_PWM_RELOAD_SELECT_BIT];
        ecov_q <= wr_data_q[CAW_PWM_ECOV];
        cl_q <= wr_data_q[CAW_PWM_CL_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags: a hardware set in the same cycle beats a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cf_q <= 1'b0;
      intermediate_overflow_flag_q <= 1'b0;
      ccf_q <= 6'h00;
    end else if (i_clk_en) begin
      if (w_ctrl) begin
        cf_q <= wr_data_q[CAW_CTRL_CF] | (tick_en & ovf16);
        ccf_q <= wr_data_q[5:0] | ccf_set;
      end else begin
        cf_q <= cf_q | (tick_en & ovf16);
        ccf_q <= ccf_q | ccf_set;
      end
      if (w_pwm) begin
        intermediate_overflow_flag_q <= wr_data_q[CAW_PWM_INTERMEDIATE_OVERFLOW_FLAG] | (tick_en & ovf_cl);
      end else begin
        intermediate_overflow_flag_q <= intermediate_overflow_flag_q | (tick_en & ovf_cl);
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog reset pulse, one system clock long
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wdt_reset_q <= 1'b0;
    end else if (i_clk_en) begin
      wdt_reset_q <= wd_match | (w_ctrl & wdt_on & wr_data_q[CAW_CTRL_WDFLAG]);
    end
  end

  // ----------------------------------------------------------------
  // Channels: compare/reload registers, mode registers, pins
  // ----------------------------------------------------------------
  // Hardware updates come first so a software write in the same cycle wins
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CAW_NCH; i++) begin
        cap_q[i] <= 16'h0000;
        arl_q[i] <= 16'h0000;
        mode_q[i] <= '0;
      end
      pin_q <= 6'h00;
    end else if (i_clk_en) begin
      for (int i = 0; i < CAW_NCH; i++) begin
        unique case (emode[i])
          CAW_EM_FREQ: begin
            // Adding a zero high byte wraps back in 256 clocks; comparator off holds the pin
            if (tick_en && mode_q[i].ecom && lo_match[i]) begin
              pin_q[i] <= ~pin_q[i];
              cap_q[i][7:0] <= 8'(cap_q[i][7:0] + cap_q[i][15:8]);
            end
          end
          CAW_EM_PWMS: begin
            if (!mode_q[i].ecom) begin
              pin_q[i] <= 1'b0;
            end else if (tick_en && ovf_cl) begin
              if (cl_q == 2'h0) begin
                cap_q[i][7:0] <= cap_q[i][15:8];
                pin_q[i] <= (cap_q[i][15:8] == 8'h00);
              end else begin
                cap_q[i] <= arl_q[i];
                pin_q[i] <= ((arl_q[i] & cl_mask) == 16'h0000);
              end
            end else if (tick_en && pwms_match[i]) begin
              pin_q[i] <= 1'b1;
            end
          end
          CAW_EM_PWM16: begin
            if (!mode_q[i].ecom) begin
              pin_q[i] <= 1'b0;
            end else if (tick_en && ovf16) begin
              pin_q[i] <= (cap_q[i] == 16'h0000);
            end else if (tick_en && full_match[i]) begin
              pin_q[i] <= 1'b1;
            end
          end
          CAW_EM_WDOG, CAW_EM_OTHER: begin
            pin_q[i] <= pin_q[i];
          end
        endcase
        // Software side of the channel registers
        if (w_cm[i] && !((i == CAW_WD_CH) && wdt_on)) begin
          mode_q[i] <= caw_chmode_t'(wr_data_q);
        end
        if (w_lo[i]) begin
          if (reload_select_bit_q) begin
            arl_q[i][7:0] <= wr_data_q;
          end else begin
            cap_q[i][7:0] <= wr_data_q;
          end
          mode_q[i].ecom <= 1'b0;
        end
        if (w_hi[i]) begin
          if ((i == CAW_WD_CH) && wdt_on) begin
            cap_q[i][15:8] <= wd_reload;
          end else if (reload_select_bit_q) begin
            arl_q[i][15:8] <= wr_data_q;
          end else begin
            cap_q[i][15:8] <= wr_data_q;
          end
          mode_q[i].ecom <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: one write and one read at a time, byte lane 0 only
  // ----------------------------------------------------------------
  // Write: address and data are taken in any order, the write lands when both are held
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= CAW_RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_strb_q <= 1'b0;
    end else if (i_clk_en) begin
      if (awready_q && i_s_axi_awvalid) begin
        wr_addr_q <= i_s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (wready_q && i_s_axi_wvalid) begin
        wr_data_q <= i_s_axi_wdata[7:0];
        wr_strb_q <= i_s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      if (wr_do) begin
        bvalid_q <= 1'b1;
        bresp_q <= caw_addr_ok(wr_addr_q) ? CAW_RESP_OKAY : CAW_RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read mux; channel data follows the reload select
  logic [7:0] rd_byte;
  logic [2:0] r_ch;
  always_comb begin
    r_ch = 3'(i_s_axi_araddr[6:4] - CAW_CH_FIRST);
    rd_byte = 8'h00;
    if (caw_addr_ok(i_s_axi_araddr)) begin
      if (i_s_axi_araddr == CAW_A_CTRL) begin
        rd_byte = {cf_q, cr_q, ccf_q};
      end else if (i_s_axi_araddr == CAW_A_MODE) begin
        rd_byte = {idle_suspend_bit_q, watchdog_enable_bit_q, watchdog_lock_bit_q, 1'b0, cps_q, ecf_q};
      end else if (i_s_axi_araddr == CAW_A_PWMCFG) begin
        rd_byte = {reload_select_bit_q, ecov_q, intermediate_overflow_flag_q, 3'h0, cl_q};
      end else if (i_s_axi_araddr == CAW_A_CNTL) begin
        rd_byte = cnt_q[7:0];
      end else if (i_s_axi_araddr == CAW_A_CNTH) begin
        rd_byte = cnt_q[15:8];
      end else if (i_s_axi_araddr[3:0] == CAW_CH_MODE) begin
        rd_byte = mode_q[r_ch];
      end else if (i_s_axi_araddr[3:0] == CAW_CH_LOW) begin
        rd_byte = reload_select_bit_q ? arl_q[r_ch][7:0] : cap_q[r_ch][7:0];
      end else begin
        rd_byte = reload_select_bit_q ? arl_q[r_ch][15:8] : cap_q[r_ch][15:8];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= CAW_RESP_OKAY;
    end else if (i_clk_en) begin
      if (arready_q && i_s_axi_arvalid) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_byte;
        rresp_q <= caw_addr_ok(i_s_axi_araddr) ? CAW_RESP_OKAY : CAW_RESP_SLVERR;
      end else if (rvalid_q && i_s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Outputs straight from flops
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rdata = {24'h000000, rdata_q};
  assign o_channel_output_pin = pin_q;
  assign o_wdt_reset = wdt_reset_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wd_refresh;
    w_hi[CAW_WD_CH] && wdt_on;
  endsequence
  sequence s_lock_held;
    (watchdog_lock_bit_q && wdt_on) [*2];
  endsequence

  chk_cl_overflow: assert property (tick_en && ovf_cl |=> intermediate_overflow_flag_q)
    else $error("overflow flag not set on cycle overflow");
  chk_wd_run: assert property (i_clk_en && wdt_on && div_hit && !suspend
    |=> cnt_q == 16'($past(cnt_q) + 16'h1))
    else $error("counter did not step with watchdog on");
  chk_low_ecom: assert property (w_lo[0] |=> !mode_q[0].ecom)
    else $error("low byte write left comparator enabled");
  chk_high_ecom: assert property (w_hi[1] |=> mode_q[1].ecom)
    else $error("high byte write did not enable comparator");
  chk_pwm_off: assert property (i_clk_en && !mode_q[2].ecom &&
    (emode[2] == CAW_EM_PWMS || emode[2] == CAW_EM_PWM16) |=> !pin_q[2])
    else $error("disabled PWM pin not low");
  chk_wd_match: assert property (wd_match |=> o_wdt_reset)
    else $error("watchdog match gave no reset");
  chk_wd_force: assert property (w_ctrl && wdt_on && wr_data_q[CAW_CTRL_WDFLAG]
    |=> o_wdt_reset ##1 !o_wdt_reset)
    else $error("forced watchdog reset missing or too long");
  chk_lock_hold: assert property (watchdog_lock_bit_q |-> ##1 s_lock_held)
    else $error("watchdog left enabled state under lock");
  chk_wd_refresh: assert property (s_wd_refresh
    |=> cap_q[CAW_WD_CH][15:8] == $past(wd_reload))
    else $error("watchdog refresh loaded wrong value");
  chk_freq_toggle: assert property (tick_en && emode[0] == CAW_EM_FREQ && lo_match[0]
    && mode_q[0].ecom |=> pin_q[0] != $past(pin_q[0]))
    else $error("frequency output did not toggle");
  chk_pwm16_rise: assert property (tick_en && emode[3] == CAW_EM_PWM16 &&
    mode_q[3].ecom && !ovf16 && full_match[3] |=> pin_q[3])
    else $error("16-bit PWM pin not set on match");
endmodule // caw_top

// >>> dv/caw_load_model.sv
// Load model on the channel pins: counts system clocks with pin 0 high.
// Assumes the pins are levels that settle on the system clock.
`timescale 1ns/1ps
module caw_load_model (
  input wire logic i_sys_clk,
  input wire logic i_clr,
  input wire logic [5:0] i_pin,
  output logic [15:0] o_high_cnt
);
  // High-time meter; the bench clears it at the start of each window
  always_ff @(posedge i_sys_clk) begin
    if (i_clr) begin
      o_high_cnt <= 16'h0000;
    end else begin
      o_high_cnt <= o_high_cnt + 16'(i_pin[0]);
    end
  end
endmodule // caw_load_model

// >>> dv/caw_tb_top.sv
// Self-checking bench for the counter array: AXI4-Lite master, PWM duty, watchdog.
// Assumes one 50 MHz clock; read results are checked against a queue of notes.
`timescale 1ns/1ps
module caw_tb_top;
  import caw_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, clr = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, wdt_rst;
  logic [1:0] bresp, rresp;
  logic [5:0] pins;
  logic [15:0] high_cnt;
  logic [33:0] exp_q[$];
  int n_mismatch = 0, compares = 0, cyc = 0, n_wd = 0;
  always #10 sys_clk = ~sys_clk;
  caw_top i_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_cpu_idle(1'b0),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_channel_output_pin(pins),
    .o_wdt_reset(wdt_rst));
  caw_load_model i_load (.i_sys_clk(sys_clk), .i_clr(clr), .i_pin(pins), .o_high_cnt(high_cnt));
  // ----------------------------------------------------------------
  // Shared tasks; each is entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Address and data offered together, each dropped at its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] eb = CAW_RESP_OKAY);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge sys_clk); while (!bvalid);
    chk(34'(bresp), 34'(eb));
    // One idle edge so a following call never re-raises bready in the same step
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Any 256-clock window of a steady 8-bit PWM holds the same high time
  task automatic duty(input logic [15:0] e);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (257) @(posedge sys_clk);
    chk(34'(high_cnt), 34'(e));
  endtask
  // Read monitor: oldest note against each accepted read answer
  always @(posedge sys_clk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  end
  // Cycle count and watchdog pulse count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rst_n && wdt_rst) n_wd <= n_wd + 1;
  end
  initial begin
    logic [7:0] h;
    int t0;
    void'($urandom(32'h6caa));
    h = 8'($urandom_range(255, 1));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(CAW_A_MODE, {CAW_RESP_OKAY, 32'h40});
    wr(CAW_A_CTRL, 8'h20);
    repeat (2) @(posedge sys_clk);
    chk(34'(n_wd), 34'h1);
    // Watchdog off first: clock select is frozen while it runs
    wr(CAW_A_MODE, 8'h00);
    wr(CAW_A_MODE, 8'h0e);
    wr(CAW_A_CTRL, 8'h40);
    wr(8'h20, 8'h42);
    wr(8'h24, h);
    wr(8'h28, h);
    repeat (300) @(posedge sys_clk);
    duty(16'h0100 - 16'(h));
    wr(8'h24, h);
    duty(16'h0000);
    rd(8'h14, {CAW_RESP_SLVERR, 32'h0});
    wr(8'h2c, 8'h55, CAW_RESP_SLVERR);
    wr(8'h30, 8'h00);
    // Channel 2: value zero is steady high, then comparator off forces low
    wr(8'h40, 8'h42);
    wr(8'h48, 8'h00);
    repeat (300) @(posedge sys_clk);
    chk(34'(pins[2]), 34'h1);
    wr(8'h44, 8'h00);
    @(posedge sys_clk);
    chk(34'(pins[2]), 34'h0);
    // Channel 3 in 16-bit PWM: high from 0xff80 until the counter wraps
    wr(8'h50, 8'hc2);
    wr(8'h54, 8'h80);
    wr(8'h58, 8'hff);
    wr(CAW_A_CNTL, 8'h00);
    wr(CAW_A_CNTH, 8'hff);
    repeat (200) @(posedge sys_clk);
    chk(34'(pins[3]), 34'h1);
    repeat (100) @(posedge sys_clk);
    chk(34'(pins[3]), 34'h0);
    rd(CAW_A_CTRL, {CAW_RESP_OKAY, 32'hc0});
    // Channel 0 as square wave: 128 clocks between toggles is exactly half duty
    wr(8'h20, 8'h46);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h80);
    repeat (300) @(posedge sys_clk);
    duty(16'h0080);
    // 9-bit cycle: reload register written, copied into compare at overflow
    wr(CAW_A_PWMCFG, 8'h81);
    wr(8'h44, 8'h5a);
    wr(8'h48, 8'h01);
    rd(8'h44, {CAW_RESP_OKAY, 32'h5a});
    wr(CAW_A_PWMCFG, 8'h01);
    repeat (520) @(posedge sys_clk);
    rd(8'h48, {CAW_RESP_OKAY, 32'h01});
    rd(CAW_A_PWMCFG, {CAW_RESP_OKAY, 32'h21});
    // Offset of one: fires after 257 to 512 array clocks
    wr(8'h74, 8'h01);
    wr(CAW_A_MODE, 8'h4e);
    wr(8'h78, 8'h00);
    t0 = cyc;
    while (!wdt_rst) @(posedge sys_clk);
    chk(34'((cyc - t0) > 250 && (cyc - t0) < 520), 34'h1);
    // Lock set: a later disable write must leave the watchdog on
    wr(CAW_A_MODE, 8'h6e);
    wr(CAW_A_MODE, 8'h0e);
    rd(CAW_A_MODE, {CAW_RESP_OKAY, 32'h6e});
    summarize();
  end
  initial begin
    #(20 * 20000);
    n_mismatch++;
    summarize();
  end
endmodule // caw_tb_top
